/* File: bench/twpwm_master.sv */
// Two-wire bus master model that makes the clock and bus conditions
`timescale 1ns/1ps
`default_nettype none
module twpwm_master (
   input wire logic pclk,
   input wire logic sda,
   output var logic scl,
   output var logic pull
);
   initial
   begin
      scl = 1'b1;
      pull = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge pclk);
   endtask : w
   // Data moves mid-low, sampled at the end of the high phase
   task automatic bitx(input logic b, output logic r);
      pull <= ~b;
      w(3);
      scl <= 1'b1;
      w(6);
      r = sda;
      scl <= 1'b0;
      w(3);
   endtask : bitx
   task automatic start;
      pull <= 1'b0;
      w(3);
      scl <= 1'b1;
      w(6);
      pull <= 1'b1;
      w(6);
      scl <= 1'b0;
      w(3);
   endtask : start
   task automatic stop;
      pull <= 1'b1;
      w(3);
      scl <= 1'b1;
      w(6);
      pull <= 1'b0;
      w(6);
   endtask : stop
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic x;
      for (int i = 7; i >= 0; i--)
         bitx(b[i], x);
      bitx(1'b1, ack);
   endtask : wbyte
   task automatic rbyte(input logic nack, output logic [7:0] b);
      logic x;
      for (int i = 7; i >= 0; i--)
         bitx(1'b1, b[i]);
      bitx(nack, x);
   endtask : rbyte
endmodule : twpwm_master
`default_nettype wire

/* File: bench/twpwm_top_asserts.sv */
// Concurrent checks on the ports of the two-wire PWM slave
`timescale 1ns/1ps
`default_nettype none
module twpwm_top_asserts #(
   parameter int unsigned PERIOD_CYC = 640
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic pwm_o,
   input wire logic pwm_oe
);
   logic prev_r;
   logic seen_r;
   int unsigned since_r;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Cycles since the last rising edge of the output
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_r <= 1'b0;
         seen_r <= 1'b0;
         since_r <= 0;
      end
      else
      begin
         prev_r <= pwm_o;
         since_r <= since_r + 1;
         if (pwm_o && !prev_r)
         begin
            seen_r <= 1'b1;
            since_r <= 1;
         end
      end
   end
   property p_rdy; psel && !penable ##1 psel && penable |-> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no pready in access");
   property p_rdy_one; pready |=> !pready; endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
   property p_err;
      pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08});
   endproperty
   a_err: assert property (p_err) else $error("pslverr wrong");
   property p_rd_idle; !pready |-> prdata == 32'h0000_0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("prdata not zero");
   property p_sda_o; sda_o == 1'b0; endproperty
   a_sda_o: assert property (p_sda_o) else $error("sda driven high");
   property p_oe_low; $changed(sda_oe) |-> !scl_i; endproperty
   a_oe_low: assert property (p_oe_low) else $error("sda moved, scl high");
   property p_stop_rel; scl_i && $rose(sda_i) |-> !sda_oe [*8]; endproperty
   a_stop_rel: assert property (p_stop_rel) else $error("sda held after stop");
   property p_rst_on; $rose(presetn) |-> pwm_oe; endproperty
   a_rst_on: assert property (p_rst_on) else $error("output off at reset");
   property p_wrap;
      seen_r && pwm_o && !prev_r |-> since_r % PERIOD_CYC == 0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("rise off period edge");
   c_err: cover property (pready && pslverr);
   c_stop: cover property (scl_i && $rose(sda_i));
   c_ack: cover property ($rose(sda_oe));
endmodule : twpwm_top_asserts
bind twpwm_top twpwm_top_asserts #(.PERIOD_CYC(PERIOD_CYC)) chk_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .pwm_o(pwm_o), .pwm_oe(pwm_oe));
`default_nettype wire

/* File: bench/twpwm_top_test.sv */
// Self-checking bench for the two-wire PWM slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin bad_count++; $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module twpwm_top_test;
   localparam int unsigned PER = 640;
   localparam logic [3:0] TYP = twpwm_pkg::DEV_TYPE_RST;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic sda_o, sda_oe, pwm_o, pwm_oe, scl, pull, e, ack;
   logic [7:0] paddr, b;
   logic [31:0] pwdata, prdata, q;
   logic [2:0] asel;
   wire logic sda;
   int bad_count, checked, hi;
   logic [7:0] dat [6] = '{8'h00, 8'h1F, 8'h20, 8'h40, 8'h60, 8'h05};
   int exp_hi [6] = '{0, 620, 640, -1, 640, 100};
   assign sda = ~(sda_oe | pull);
   always #2 pclk = ~pclk;
   twpwm_top #(.PERIOD_CYC(PER)) twpwm_top_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .addr_sel_bit0(asel[0]), .addr_sel_bit1(asel[1]),
      .addr_sel_bit2(asel[2]), .pwm_o(pwm_o), .pwm_oe(pwm_oe));
   twpwm_master twpwm_master_inst (.pclk(pclk), .sda(sda), .scl(scl),
      .pull(pull));
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      logic late;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      late = (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (late)
      begin
         bad_count++;
         conclude();
      end
   endtask : apb
   task automatic xfer(input logic [2:0] s, input logic [7:0] d,
      input logic nak);
      twpwm_master_inst.start();
      twpwm_master_inst.wbyte({TYP, s, 1'b0}, ack);
      `CHK("ctrl ack", nak, ack)
      if (nak == 1'b0)
      begin
         twpwm_master_inst.wbyte(d, ack);
         `CHK("data ack", 1'b0, ack)
      end
      twpwm_master_inst.stop();
   endtask : xfer
   // Counts high cycles over one period after the setting has landed
   task automatic measure;
      repeat (2 * PER + 20) @(posedge pclk);
      hi = 0;
      repeat (PER)
      begin
         @(posedge pclk);
         if (pwm_o === 1'b1)
            hi++;
      end
   endtask : measure
   initial
   begin
      repeat (100000) @(posedge pclk);
      bad_count++;
      conclude();
   end
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      asel = 3'b101;
      bad_count = 0;
      checked = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      apb(1'b0, twpwm_pkg::REG_CTRL, 32'h0000_0000);
      `CHK("ctrl", 1'b1, q[0])
      apb(1'b0, twpwm_pkg::REG_STAT, 32'h0000_0000);
      `CHK("stat", 9'h010, q[8:0])
      apb(1'b0, 8'h0C, 32'h0000_0000);
      `CHK("unmapped err", 1'b1, e)
      `CHK("unmapped data", 32'h0000_0000, q)
      measure();
      `CHK("half scale", 320, hi)
      for (int i = 0; i < 6; i++)
      begin
         xfer(3'b101, dat[i], 1'b0);
         measure();
         `CHK("drive", (i != 3), pwm_oe)
         if (exp_hi[i] >= 0)
            `CHK("high time", exp_hi[i], hi)
      end
      xfer(3'b100, 8'h00, 1'b1);
      twpwm_master_inst.start();
      twpwm_master_inst.wbyte({TYP, 3'b101, 1'b0}, ack);
      twpwm_master_inst.start();
      twpwm_master_inst.wbyte({TYP, 3'b101, 1'b1}, ack);
      `CHK("read ack", 1'b0, ack)
      twpwm_master_inst.rbyte(1'b0, b);
      `CHK("read byte", 8'h05, b)
      twpwm_master_inst.rbyte(1'b1, b);
      `CHK("last byte", 8'h05, b)
      twpwm_master_inst.stop();
      apb(1'b1, twpwm_pkg::REG_CTRL, 32'h0000_0000);
      xfer(3'b101, 8'h00, 1'b1);
      apb(1'b1, twpwm_pkg::REG_CTRL, 32'h0000_0001);
      apb(1'b1, twpwm_pkg::REG_STAT, 32'hFFFF_FFFF);
      `CHK("ro write err", 1'b0, e)
      apb(1'b0, twpwm_pkg::REG_STAT, 32'h0000_0000);
      `CHK("stat kept", 8'h05, q[7:0])
      `CHK("last dir", 1'b1, q[twpwm_pkg::STAT_RW_BIT])
      // Unknown command code is acknowledged and changes no setting
      xfer(3'b101, 8'h9F, 1'b0);
      apb(1'b0, twpwm_pkg::REG_STAT, 32'h0000_0000);
      `CHK("bad cmd", 8'h05, q[7:0])
      `CHK("write dir", 1'b0, q[twpwm_pkg::STAT_RW_BIT])
      apb(1'b0, twpwm_pkg::REG_XFER, 32'h0000_0000);
      `CHK("byte counts", 32'h0002_0007, q)
      conclude();
   end
endmodule : twpwm_top_test
`default_nettype wire

/* File: logic/twpwm_pkg.sv */
// Shared constants and types of the two-wire PWM slave
`default_nettype none
package twpwm_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned PWM_FREQ_HZ = 1000;
   localparam int DUTY_W = 5;
   localparam logic [4:0] DUTY_RST = 5'h10;
   localparam logic [2:0] CMD_DUTY = 3'h0;
   localparam logic [2:0] CMD_FULL = 3'h1;
   localparam logic [2:0] CMD_SHDN = 3'h2;
   localparam logic [2:0] CMD_RECALL = 3'h3;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] DEV_TYPE_RST = 4'hA;
   localparam int APB_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_XFER = 8'h08;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int STAT_BUSY_BIT = 8;
   localparam int STAT_PWM_BIT = 9;
   localparam int STAT_RW_BIT = 10;
   localparam logic [15:0] CNT_RST = 16'h0000;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_DACK, ST_TX, ST_TACK
   } twpwm_state_t;
endpackage : twpwm_pkg
`default_nettype wire

/* File: logic/twpwm_pwm.sv */
// Fixed-period 5-bit pulse-width generator with full-on and shutdown
`timescale 1ns/1ps
`default_nettype none
module twpwm_pwm #(
   parameter int unsigned PERIOD_CYC = 250_000,
   parameter int CW = $clog2(PERIOD_CYC + 1)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] duty,
   input wire logic full_on,
   input wire logic shutdown,
   output logic pwm_o,
   output logic pwm_oe
);
   localparam int PW = CW + twpwm_pkg::DUTY_W;
   localparam logic [PW-1:0] RST_PROD =
      PW'(twpwm_pkg::DUTY_RST) * PW'(PERIOD_CYC);
   localparam logic [CW-1:0] THR_RST = RST_PROD[PW-1:twpwm_pkg::DUTY_W];
   localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] thr_r;
   logic full_r;
   logic shdn_r;
   logic [PW-1:0] prod;
   logic wrap;

   // High time is duty/32 of the period, truncated to whole cycles
   assign prod = PW'(duty) * PW'(PERIOD_CYC);
   assign wrap = (cnt_r == LAST);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_r <= '0;
      else if (wrap)
         cnt_r <= '0;
      else
         cnt_r <= cnt_r + 1'b1;
   end

   // New settings only at the period boundary, so no pulse is cut short
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         thr_r <= THR_RST;
         full_r <= 1'b0;
         shdn_r <= 1'b0;
      end
      else if (wrap)
      begin
         thr_r <= prod[PW-1:twpwm_pkg::DUTY_W];
         full_r <= full_on;
         shdn_r <= shutdown;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pwm_o <= 1'b0;
         pwm_oe <= 1'b1;
      end
      else
      begin
         pwm_o <= full_r | (cnt_r < thr_r);
         pwm_oe <= ~shdn_r;
      end
   end
endmodule : twpwm_pwm
`default_nettype wire

/* File: logic/twpwm_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module twpwm_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
      end
      else
      begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A change is accepted only once stages two and three agree
   genvar i;
   for (i = 0; i < WIDTH; i++)
   begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
            dout[i] <= RST_VAL[i];
         else if (s2_r[i] == s3_r[i])
            dout[i] <= s3_r[i];
      end
   end
endmodule : twpwm_sync
`default_nettype wire

/* File: logic/twpwm_top.sv */
// Two-wire addressed slave controlling a 5-bit PWM, with APB status port
// Function
// - After reset the duty code is half scale, giving 50% duty.
// - A 5-bit duty code sets 0% to 96.88% in equal steps.
// - A separate command forces the output fully on, 100% duty.
// - Output frequency is fixed by a build parameter, not by software.
// - Device is a slave only; drives data open-drain, never the clock.
// - Data changes while clock is high are control conditions.
// - Data falling while clock is high is a START.
// - Data rising while clock is high is a STOP.
// - Data changes in clock low; one bit sampled per clock high.
// - Bytes are eight bits plus a ninth acknowledge bit.
// - Port works at both 100kHz and 400kHz bus clocks.
// - Acknowledger holds data low through the ninth clock high.
// - First written byte is the control byte; every byte acknowledged.
// - On read, acknowledge control byte, then send until master NACKs.
// - STOP or repeated START ends the transfer; START opens another.
// - Address is matched in hardware; read bit turns device transmitter.
// - Three address-select pins give eight addresses on one bus.
// - Control byte: type code, three select bits, direction bit.
// - Data byte: low five bits duty, top three bits command.
// - Shutdown floats the output; recall restores the prior setting.
// - All bytes travel most significant bit first.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module twpwm_top #(
   parameter int unsigned PWM_FREQ_HZ = twpwm_pkg::PWM_FREQ_HZ,
   parameter int unsigned PERIOD_CYC = twpwm_pkg::CLK_HZ / PWM_FREQ_HZ,
   // Device type code: arbitrary value
   parameter logic [3:0] DEV_TYPE = twpwm_pkg::DEV_TYPE_RST
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [twpwm_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic addr_sel_bit0,
   input wire logic addr_sel_bit1,
   input wire logic addr_sel_bit2,
   output logic pwm_o,
   output logic pwm_oe
);
   twpwm_pkg::twpwm_state_t state_r;
   logic scl_s;
   logic sda_s;
   logic [2:0] asel_s;
   logic scl_q_r;
   logic sda_q_r;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [7:0] shift_r;
   logic [3:0] bit_cnt_r;
   logic rw_r;
   logic mack_r;
   logic addr_hit;
   logic byte_full;
   logic apply;
   logic [4:0] duty_r;
   logic full_r;
   logic shdn_r;
   logic [7:0] cfg_byte;
   logic ctrl_en_r;
   logic [15:0] rx_cnt_r;
   logic [15:0] tx_cnt_r;
   logic apb_setup;
   logic apb_acc;
   logic apb_hit;
   logic [31:0] rd_nxt;

   // Bus pins cross into pclk through the filtered synchronisers
   twpwm_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_scl_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(scl_i),
      .dout(scl_s)
   );

   twpwm_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sda_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(sda_i),
      .dout(sda_s)
   );

   twpwm_sync #(.WIDTH(3), .RST_VAL(3'h0)) u_asel_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din({addr_sel_bit2, addr_sel_bit1, addr_sel_bit0}),
      .dout(asel_s)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end
      else
      begin
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_q_r;
   assign scl_fall = ~scl_s & scl_q_r;
   // Data moving with clock held high is a condition, never a bit
   assign start_c = scl_s & scl_q_r & sda_q_r & ~sda_s;
   assign stop_c = scl_s & scl_q_r & ~sda_q_r & sda_s;

   assign byte_full = (bit_cnt_r == twpwm_pkg::BYTE_BITS);
   assign addr_hit = (shift_r[7:4] == DEV_TYPE) &&
                     (shift_r[3:1] == asel_s);
   assign apply = (state_r == twpwm_pkg::ST_RX) && scl_fall && byte_full;
   assign cfg_byte = {shdn_r, full_r, 1'b0, duty_r};

   // Serial protocol engine; the pad only ever pulls low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= twpwm_pkg::ST_IDLE;
         shift_r <= '0;
         bit_cnt_r <= '0;
         rw_r <= 1'b0;
         mack_r <= 1'b0;
         sda_oe <= 1'b0;
      end
      else if (stop_c || !ctrl_en_r)
      begin
         state_r <= twpwm_pkg::ST_IDLE;
         sda_oe <= 1'b0;
      end
      else if (start_c)
      begin
         state_r <= twpwm_pkg::ST_ADDR;
         bit_cnt_r <= '0;
         sda_oe <= 1'b0;
      end
      else
      begin
         case (state_r)
            twpwm_pkg::ST_ADDR, twpwm_pkg::ST_RX:
            begin
               if (scl_rise && !byte_full)
               begin
                  shift_r <= {shift_r[6:0], sda_s};
                  bit_cnt_r <= bit_cnt_r + 1'b1;
               end
               else if (scl_fall && byte_full)
               begin
                  if (state_r == twpwm_pkg::ST_RX)
                  begin
                     sda_oe <= 1'b1;
                     state_r <= twpwm_pkg::ST_DACK;
                  end
                  else if (addr_hit)
                  begin
                     rw_r <= shift_r[0];
                     sda_oe <= 1'b1;
                     state_r <= twpwm_pkg::ST_AACK;
                  end
                  else
                     state_r <= twpwm_pkg::ST_IDLE;
               end
            end
            twpwm_pkg::ST_AACK, twpwm_pkg::ST_DACK:
            begin
               if (scl_fall)
               begin
                  bit_cnt_r <= '0;
                  if (state_r == twpwm_pkg::ST_AACK && rw_r)
                  begin
                     shift_r <= cfg_byte;
                     sda_oe <= ~cfg_byte[7];
                     state_r <= twpwm_pkg::ST_TX;
                  end
                  else
                  begin
                     sda_oe <= 1'b0;
                     state_r <= twpwm_pkg::ST_RX;
                  end
               end
            end
            twpwm_pkg::ST_TX:
            begin
               if (scl_rise)
                  bit_cnt_r <= bit_cnt_r + 1'b1;
               else if (scl_fall)
               begin
                  if (byte_full)
                  begin
                     sda_oe <= 1'b0;
                     state_r <= twpwm_pkg::ST_TACK;
                  end
                  else
                  begin
                     shift_r <= {shift_r[6:0], 1'b0};
                     sda_oe <= ~shift_r[6];
                  end
               end
            end
            twpwm_pkg::ST_TACK:
            begin
               if (scl_rise)
                  mack_r <= ~sda_s;
               else if (scl_fall)
               begin
                  bit_cnt_r <= '0;
                  if (mack_r)
                  begin
                     shift_r <= cfg_byte;
                     sda_oe <= ~cfg_byte[7];
                     state_r <= twpwm_pkg::ST_TX;
                  end
                  else
                     state_r <= twpwm_pkg::ST_IDLE;
               end
            end
            twpwm_pkg::ST_IDLE:
            begin
               sda_oe <= 1'b0;
            end
            default:
            begin
               state_r <= twpwm_pkg::ST_IDLE;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain pad: the driven level is always low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sda_o <= 1'b0;
      else
         sda_o <= 1'b0;
   end

   // Configuration updated when a data byte is acknowledged
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         duty_r <= twpwm_pkg::DUTY_RST;
         full_r <= 1'b0;
         shdn_r <= 1'b0;
      end
      else if (apply)
      begin
         case (shift_r[7:5])
            twpwm_pkg::CMD_DUTY:
            begin
               duty_r <= shift_r[4:0];
               full_r <= 1'b0;
            end
            twpwm_pkg::CMD_FULL:
               full_r <= 1'b1;
            twpwm_pkg::CMD_SHDN:
               shdn_r <= 1'b1;
            twpwm_pkg::CMD_RECALL:
               shdn_r <= 1'b0;
            default:
               shdn_r <= shdn_r;
         endcase
      end
   end

   // Byte counters for software visibility, wrapping
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_cnt_r <= twpwm_pkg::CNT_RST;
         tx_cnt_r <= twpwm_pkg::CNT_RST;
      end
      else
      begin
         if (apply)
            rx_cnt_r <= rx_cnt_r + 1'b1;
         if (state_r == twpwm_pkg::ST_TX && scl_fall && byte_full)
            tx_cnt_r <= tx_cnt_r + 1'b1;
      end
   end

   twpwm_pwm #(.PERIOD_CYC(PERIOD_CYC)) u_pwm (
      .clk(pclk),
      .rst_n(presetn),
      .duty(duty_r),
      .full_on(full_r),
      .shutdown(shdn_r),
      .pwm_o(pwm_o),
      .pwm_oe(pwm_oe)
   );

   // APB slave: one wait-free access phase, answers registered
   assign apb_setup = psel & ~penable;
   assign apb_acc = psel & penable & pready;
   assign apb_hit = (paddr == twpwm_pkg::REG_CTRL) ||
                    (paddr == twpwm_pkg::REG_STAT) ||
                    (paddr == twpwm_pkg::REG_XFER);

   always_comb
   begin
      rd_nxt = '0;
      case (paddr)
         twpwm_pkg::REG_CTRL:
            rd_nxt[twpwm_pkg::CTRL_EN_BIT] = ctrl_en_r;
         twpwm_pkg::REG_STAT:
         begin
            rd_nxt[7:0] = cfg_byte;
            rd_nxt[twpwm_pkg::STAT_BUSY_BIT] =
               (state_r != twpwm_pkg::ST_IDLE);
            rd_nxt[twpwm_pkg::STAT_PWM_BIT] = pwm_o;
            rd_nxt[twpwm_pkg::STAT_RW_BIT] = rw_r;
         end
         twpwm_pkg::REG_XFER:
            rd_nxt = {tx_cnt_r, rx_cnt_r};
         default:
            rd_nxt = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         pready <= apb_setup;
         pslverr <= apb_setup & ~apb_hit;
         prdata <= (apb_setup && !pwrite) ? rd_nxt : '0;
      end
   end

   // Port enable; clearing it drops any transfer and ignores the bus
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_en_r <= twpwm_pkg::CTRL_EN_RST;
      else if (apb_acc && pwrite && paddr == twpwm_pkg::REG_CTRL)
         ctrl_en_r <= pwdata[twpwm_pkg::CTRL_EN_BIT];
   end
endmodule : twpwm_top
`default_nettype wire
